// [logic/pewc_pkg.sv]
// package for the parallel eeprom host controller: timing, commands, types
package pewc_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int unsigned ADDR_W          = 15;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned PAGE_BYTES      = 64;
  localparam int unsigned PAGE_LSB        = 6;
  // strobe timing in ns
  localparam int unsigned WE_PULSE_NS     = 100;
  localparam int unsigned WE_HIGH_NS      = 50;
  localparam int unsigned READ_ACC_NS     = 120;
  localparam int unsigned OE_HIGH_NS      = 150;
  localparam int unsigned WE_PULSE_CYC    = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WE_HIGH_CYC     = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned READ_ACC_CYC    = (READ_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int unsigned OE_HIGH_CYC     = (OE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  // byte load window, a longest time in us, rounded down
  localparam int unsigned BYTE_LOAD_US    = 150;
  localparam int unsigned BYTE_LOAD_CYC   = BYTE_LOAD_US * (CLK_HZ / 1_000_000);
  // self-timed write period in us, standard and fast option
  localparam int unsigned WRITE_STD_US    = 10_000;
  localparam int unsigned WRITE_FAST_US   = 3_000;
  localparam int unsigned WRITE_STD_CYC   = WRITE_STD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WRITE_FAST_CYC  = WRITE_FAST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W           = 20;
  // identification area bounds
  localparam logic [14:0] ID_AREA_LO      = 15'h7FC0;
  localparam logic [14:0] ID_AREA_HI      = 15'h7FFF;
  localparam int unsigned POLL_BIT        = 7;
  localparam int unsigned TOGGLE_BIT      = 6;
  // host command codes
  localparam logic [2:0]  CMD_READ        = 3'h0;
  localparam logic [2:0]  CMD_WRITE       = 3'h1;
  localparam logic [2:0]  CMD_WAIT_POLL   = 3'h2;
  localparam logic [2:0]  CMD_WAIT_TOGGLE = 3'h3;

  // one host request
  typedef struct packed {
    logic [2:0]  cmd;       // operation
    logic [14:0] addr;      // byte address
    logic [7:0]  data;      // write data
    logic        id_area;   // raise id select high voltage for an id area address
    logic        last;      // final byte of page or sequence
  } pewc_req_t;

  // memory-side pins
  typedef struct packed {
    logic [14:0] addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        id_sel_hv;
    logic [7:0]  dq_o;
    logic        dq_oe;
  } pewc_pins_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_LOAD_WAIT, ST_RD_ACC,
    ST_RD_GAP, ST_PROG, ST_DONE
  } pewc_state_t;
endpackage

// [logic/pewc_host.sv]
// host controller that drives a byte-wide parallel eeprom over its pins
`timescale 1ns/1ps
`default_nettype none
module pewc_host
  import pewc_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_STD_CYC,  // write period, long count
  parameter int unsigned LOAD_CYC  = BYTE_LOAD_CYC   // byte load window
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire pewc_req_t   req,
  input  wire logic        req_valid,
  output logic             req_ready,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             busy,
  output logic             timeout_err,
  output pewc_pins_t       pins,
  input  wire logic [7:0]  dq_i
);

  pewc_state_t state_ff, nxt_state;       // sequencer
  pewc_pins_t  pins_ff, nxt_pins;         // registered pin drive
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;      // phase / window counter
  logic [8:0]  page_ff, nxt_page;         // page of the current load
  logic        loading_ff, nxt_loading;   // a page load is open
  logic [7:0]  last_ff, nxt_last;         // last byte written
  logic [2:0]  cmd_ff, nxt_cmd;           // command in progress
  logic        fin_ff, nxt_fin;           // byte in flight closes its load
  logic [7:0]  prev_ff, nxt_prev;         // previous read for toggle test
  logic        prev_ok_ff, nxt_prev_ok;   // prev_ff holds a read
  logic [7:0]  rd_ff, nxt_rd;
  logic        rdv_ff, nxt_rdv;
  logic        err_ff, nxt_err;

  // decode of the incoming request
  wire         take      = req_valid && (state_ff == ST_IDLE || state_ff == ST_LOAD_WAIT);
  wire [8:0]   req_page  = req.addr[14:6];
  wire         id_ok     = req.addr >= ID_AREA_LO;
  wire         page_bad  = loading_ff && (req_page != page_ff);
  wire         is_write  = req.cmd == CMD_WRITE;
  wire         poll_done = dq_i[POLL_BIT] == last_ff[POLL_BIT];
  wire         tog_done  = prev_ok_ff && (dq_i[TOGGLE_BIT] == prev_ff[TOGGLE_BIT]);
  wire         cnt_zero  = cnt_ff == '0;

  // cut a cycle count, less one, to the counter width
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n - 1);
  endfunction

  // next-state logic
  always_comb begin
    nxt_state   = state_ff;
    nxt_pins    = pins_ff;
    nxt_cnt     = cnt_zero ? cnt_ff : cnt_ff - 1'b1;
    nxt_page    = page_ff;
    nxt_loading = loading_ff;
    nxt_last    = last_ff;
    nxt_cmd     = cmd_ff;
    nxt_fin     = fin_ff;
    nxt_prev    = prev_ff;
    nxt_prev_ok = prev_ok_ff;
    nxt_rd      = rd_ff;
    nxt_rdv     = 1'b0;
    nxt_err     = 1'b0;
    case (state_ff)
      ST_IDLE, ST_LOAD_WAIT: begin
        if (take) begin
          nxt_cmd            = req.cmd;
          nxt_pins.addr      = req.addr;
          nxt_pins.id_sel_hv = req.id_area && id_ok;
          if (is_write && !page_bad) begin
            // write: ce low, oe high, we pulse; address at we fall
            nxt_pins.ce_n  = 1'b0;
            nxt_pins.oe_n  = 1'b1;
            nxt_pins.we_n  = 1'b0;
            nxt_pins.dq_o  = req.data;
            nxt_pins.dq_oe = 1'b1;
            nxt_page       = req_page;
            nxt_last       = req.data;
            nxt_fin        = req.last;
            nxt_cnt        = cyc(WE_PULSE_CYC);
            nxt_state      = ST_WR_LOW;
          end else if (is_write) begin
            nxt_err = 1'b1;
          end else if (state_ff == ST_IDLE) begin
            // read or busy wait: drive ce, oe low, float data
            nxt_pins.ce_n  = 1'b0;
            nxt_pins.oe_n  = 1'b0;
            nxt_pins.we_n  = 1'b1;
            nxt_pins.dq_oe = 1'b0;
            nxt_prev_ok    = 1'b0;
            nxt_cnt        = cyc(READ_ACC_CYC);
            nxt_state      = ST_RD_ACC;
          end
        end else if (state_ff == ST_LOAD_WAIT && cnt_zero) begin
          nxt_state = ST_PROG;
          nxt_cnt   = cyc(WRITE_CYC);
        end
      end
      ST_WR_LOW: begin
        if (cnt_zero) begin
          // rising strobe: data latched here, held one more cycle
          nxt_pins.we_n = 1'b1;
          nxt_pins.ce_n = 1'b1;
          nxt_cnt       = cyc(WE_HIGH_CYC);
          nxt_state     = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        if (cnt_zero) begin
          nxt_pins.dq_oe = 1'b0;
          nxt_loading    = 1'b1;
          // further bytes of the same page continue inside window
          nxt_cnt        = cyc(LOAD_CYC);
          nxt_state      = ST_LOAD_WAIT;
          // last flag latched at take; req may already carry the next byte
          if (fin_ff) begin
            nxt_cnt   = cyc(WRITE_CYC);
            nxt_state = ST_PROG;
          end
        end
      end
      ST_PROG: begin
        // self-timed write; done only when the WRITE_CYC count runs out
        nxt_loading = 1'b0;
        nxt_pins.id_sel_hv = 1'b0;
        if (cnt_zero) begin
          nxt_state = ST_DONE;
        end
      end
      ST_RD_ACC: begin
        if (cnt_zero) begin
          nxt_pins.oe_n = 1'b1;
          nxt_pins.ce_n = 1'b1;
          nxt_rd        = dq_i;
          nxt_cnt       = cyc(OE_HIGH_CYC);
          nxt_state     = ST_RD_GAP;
          if (cmd_ff == CMD_READ) begin
            nxt_rdv   = 1'b1;
            nxt_state = ST_DONE;
          end else if ((cmd_ff == CMD_WAIT_POLL && poll_done) ||
                       (cmd_ff == CMD_WAIT_TOGGLE && tog_done)) begin
            nxt_rdv   = 1'b1;
            nxt_state = ST_DONE;
          end
          nxt_prev    = dq_i;
          nxt_prev_ok = 1'b1;
        end
      end
      ST_RD_GAP: begin
        // oe high between polls so each read toggles the device
        if (cnt_zero) begin
          nxt_pins.ce_n = 1'b0;
          nxt_pins.oe_n = 1'b0;
          nxt_cnt       = cyc(READ_ACC_CYC);
          nxt_state     = ST_RD_ACC;
        end
      end
      ST_DONE: begin
        nxt_pins.ce_n      = 1'b1;
        nxt_pins.oe_n      = 1'b1;
        nxt_pins.id_sel_hv = 1'b0;
        nxt_state          = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff   <= ST_IDLE;
      pins_ff    <= '{addr: 15'h0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                      id_sel_hv: 1'b0, dq_o: 8'h00, dq_oe: 1'b0};
      cnt_ff     <= '0;
      page_ff    <= 9'h000;
      loading_ff <= 1'b0;
      last_ff    <= 8'h00;
      cmd_ff     <= CMD_READ;
      fin_ff     <= 1'b0;
      prev_ff    <= 8'h00;
      prev_ok_ff <= 1'b0;
      rd_ff      <= 8'h00;
      rdv_ff     <= 1'b0;
      err_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      pins_ff    <= nxt_pins;
      cnt_ff     <= nxt_cnt;
      page_ff    <= nxt_page;
      loading_ff <= nxt_loading;
      last_ff    <= nxt_last;
      cmd_ff     <= nxt_cmd;
      fin_ff     <= nxt_fin;
      prev_ff    <= nxt_prev;
      prev_ok_ff <= nxt_prev_ok;
      rd_ff      <= nxt_rd;
      rdv_ff     <= nxt_rdv;
      err_ff     <= nxt_err;
    end
  end

  // ready and busy flops mirror the next state
  logic rdy_ff, busy_ff;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdy_ff  <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      rdy_ff  <= nxt_state == ST_IDLE || nxt_state == ST_LOAD_WAIT;
      busy_ff <= nxt_state == ST_PROG;
    end
  end

  assign req_ready   = rdy_ff;
  assign busy        = busy_ff;
  assign rd_data     = rd_ff;
  assign rd_valid    = rdv_ff;
  assign timeout_err = err_ff;
  assign pins        = pins_ff;

endmodule // pewc_host
`default_nettype wire

// [tb/pewc_host_props.sv]
// checker for the eeprom host controller ports
`timescale 1ns/1ps
`default_nettype none
module pewc_host_props
  import pewc_pkg::*;
#(
  parameter int unsigned WRITE_CYC = 50,
  parameter int unsigned LOAD_CYC  = 20
) (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire pewc_req_t  req,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       busy,
  input wire logic       timeout_err,
  input wire pewc_pins_t pins,
  input wire logic [7:0] dq_i
);
  logic        we_q_ff, load_ff; // strobe delay, load open
  logic [8:0]  page_ff;          // page of this load
  logic [19:0] lcnt_ff, bcnt_ff; // strobe gap, busy length
  wire         wr_fall = !pins.we_n && we_q_ff;
  // track strobes, load span, busy length
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {load_ff, page_ff, lcnt_ff, bcnt_ff} <= '0;
      we_q_ff <= 1'b1;
    end else begin
      we_q_ff <= pins.we_n;
      load_ff <= !busy && (load_ff || wr_fall);
      if (wr_fall && !load_ff) page_ff <= pins.addr[14:6];
      lcnt_ff <= (load_ff && !wr_fall) ? lcnt_ff + 20'h1 : '0;
      bcnt_ff <= busy ? bcnt_ff + 20'h1 : '0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_strobe;
    !pins.ce_n && pins.oe_n && pins.dq_oe ##1 pins.we_n && pins.dq_oe;
  endsequence
  sequence s_read;
    (!pins.ce_n && pins.we_n && !pins.dq_oe && !pins.oe_n)[*3] ##1 pins.oe_n;
  endsequence
  property p_strobe; $fell(pins.we_n) |-> s_strobe; endproperty
  property p_read; $fell(pins.oe_n) |-> s_read; endproperty
  property p_rd_data; rd_valid |-> rd_data == $past(dq_i); endproperty
  property p_clash; !pins.oe_n |-> !pins.dq_oe && pins.we_n; endproperty
  property p_busy; $fell(busy) |-> bcnt_ff >= WRITE_CYC && bcnt_ff <= WRITE_CYC + 1;
  endproperty
  property p_page; wr_fall && load_ff |-> pins.addr[14:6] == page_ff; endproperty
  property p_window; load_ff |-> lcnt_ff <= LOAD_CYC + 4; endproperty
  property p_id; pins.id_sel_hv |-> pins.addr >= ID_AREA_LO; endproperty
  a_strobe: assert property (p_strobe) else $error("bad strobe");
  a_read: assert property (p_read) else $error("bad read");
  a_rd_data: assert property (p_rd_data) else $error("bad data");
  a_clash: assert property (p_clash) else $error("clash");
  a_busy: assert property (p_busy) else $error("bad busy");
  a_page: assert property (p_page) else $error("page moved");
  a_window: assert property (p_window) else $error("window");
  a_id: assert property (p_id) else $error("id select");
endmodule // pewc_host_props
`default_nettype wire

// [tb/pewc_eeprom_model.sv]
// behavioural eeprom: load window, timed write, status bits
`timescale 1ns/1ps
`default_nettype none
module pewc_eeprom_model #(
  parameter int LOAD_NS = 2000,
  parameter int WR_NS   = 6000
) (
  input  wire logic [14:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        id_hv,
  input  wire logic [7:0]  din,
  output logic [7:0]       dq,
  output logic             dq_en
);
  logic [7:0]  mem [int];   // array, bit 15 of key is id area
  logic [7:0]  pg [int];    // page buffer
  logic [7:0]  ld_q = 8'h00;
  logic [15:0] key_q = 16'h0000;
  logic        prog = 1'b0; // timed write running
  logic        tog = 1'b0;
  logic        armed = 1'b0;
  time         t_ld = 0;    // last byte load
  wire  [15:0] key = {id_hv && addr >= 15'h7FC0, addr};
  // address at the later strobe fall
  always @(negedge we_n) begin
    #1;
    armed = !ce_n && oe_n && !prog;
    key_q = key;
  end
  // data at the first strobe rise
  always @(posedge we_n) if (armed) begin
    pg[key_q] = din;
    ld_q = din;
    t_ld = $time;
    armed = 1'b0;
  end
  // window expiry starts the timed write
  always begin
    #100;
    if (pg.num() > 0 && !prog && $time - t_ld >= LOAD_NS) begin
      prog = 1'b1;
      #(WR_NS);
      foreach (pg[k]) mem[k] = pg[k];
      pg.delete();
      prog = 1'b0;
    end
  end
  always @(negedge oe_n) if (prog) tog = !tog;
  assign dq_en = !ce_n && !oe_n && we_n;
  always @(key or prog or tog)
    dq = prog ? {~ld_q[7], tog, ld_q[5:0]} : mem.exists(key) ? mem[key] : 8'hFF;
endmodule // pewc_eeprom_model
`default_nettype wire

// [tb/pewc_host_tb_top.sv]
// self-checking bench for the eeprom host controller
`timescale 1ns/1ps
`default_nettype none
module pewc_host_tb_top;
  import pewc_pkg::*;
  logic        clk_sys, nrst, req_valid, req_ready, rd_valid, busy, timeout_err, m_en;
  logic        to_seen = 1'b0;
  logic [7:0]  rd_data, dq_i, m_q;
  logic [7:0]  dq_last = 8'h00;
  pewc_req_t   req;
  pewc_pins_t  pins;
  logic [31:0] seed = 32'h6384;
  logic [7:0]  exp_mem [int]; // mirror of the array
  int          mismatches = 0, compares = 0;
  // bus: device, host, else inverse of last level
  assign dq_i = m_en ? m_q : pins.dq_oe ? pins.dq_o : ~dq_last;
  always @(posedge clk_sys) dq_last <= dq_i;
  always @(posedge clk_sys) if (timeout_err) to_seen <= 1'b1;
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  pewc_host #(.WRITE_CYC(50), .LOAD_CYC(20)) DUT (.clk_sys(clk_sys), .nrst(nrst),
    .req(req), .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .timeout_err(timeout_err), .pins(pins), .dq_i(dq_i));
  pewc_eeprom_model #(.LOAD_NS(2000), .WR_NS(6000)) u_mem (.addr(pins.addr),
    .ce_n(pins.ce_n), .oe_n(pins.oe_n), .we_n(pins.we_n), .id_hv(pins.id_sel_hv),
    .din(dq_i), .dq(m_q), .dq_en(m_en));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic int key(logic id, logic [14:0] a);
    return int'({id && a >= ID_AREA_LO, a});
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic send(input logic [2:0] c, input logic [14:0] a, input logic [7:0] d,
                      input logic id, input logic lst);
    int n = 0;
    @(negedge clk_sys);
    req = '{c, a, d, id, lst};
    req_valid = 1'b1;
    while (!req_ready && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, req_ready}, 8'h01);
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask
  task automatic rd_cmp(input logic [14:0] a, input logic id);
    int n = 0;
    send(CMD_READ, a, 8'h00, id, 1'b0);
    while (rd_valid !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, exp_mem.exists(key(id, a)) ? exp_mem[key(id, a)] : 8'hFF);
  endtask
  // load a page, maybe an off-page byte, wait for the end, read back
  task automatic page(input logic [14:0] b, input int cnt, input logic id, input logic lst,
                      input logic [2:0] wcmd, input logic bad);
    logic [7:0] d;
    int n = 0;
    to_seen = 1'b0;
    for (int i = 0; i < cnt; i++) begin
      d = rnd();
      send(CMD_WRITE, b + 15'(i), d, id, lst && i == cnt - 1);
      exp_mem[key(id, b + 15'(i))] = d;
    end
    if (bad) send(CMD_WRITE, b ^ 15'h4000, 8'h5A, id, 1'b0);
    while (!busy && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, busy}, 8'h01);
    send(wcmd, b + 15'(cnt - 1), d, id, 1'b0);
    n = 0;
    while (rd_valid !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, d);
    chk({7'h00, to_seen}, {7'h00, bad});
    if (bad) rd_cmp(b ^ 15'h4000, id);
    for (int i = 0; i < cnt; i++) rd_cmp(b + 15'(i), id);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(100 * 40000);
    mismatches++;
    wrap_up();
  end
  initial begin
    req = '0;
    req_valid = 1'b0;
    nrst = 1'b0;
    repeat (20) @(posedge clk_sys);
    chk({5'h00, req_ready, busy, pins.we_n}, 8'h05);
    @(negedge clk_sys);
    nrst = 1'b1;
    page(15'h0000, 1, 1'b0, 1'b1, CMD_WAIT_POLL, 1'b0);
    page(15'h0040, 64, 1'b0, 1'b0, CMD_WAIT_TOGGLE, 1'b0);
    for (int p = 0; p < 4; p++) begin
      page({1'b0, rnd(), 6'h00}, 2 + int'(rnd()) % 62, 1'b0, p[0],
           p[1] ? CMD_WAIT_TOGGLE : CMD_WAIT_POLL, !p[0]);
    end
    page(ID_AREA_LO, 4, 1'b1, 1'b1, CMD_WAIT_POLL, 1'b0);
    for (int i = 0; i < 4; i++) rd_cmp(ID_AREA_LO + 15'(i), 1'b0);
    wrap_up();
  end
endmodule // pewc_host_tb_top
bind pewc_host pewc_host_props #(.WRITE_CYC(WRITE_CYC), .LOAD_CYC(LOAD_CYC)) u_props (
  .clk_sys(clk_sys), .nrst(nrst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
  .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .timeout_err(timeout_err),
  .pins(pins), .dq_i(dq_i));
`default_nettype wire
